// ==== core/pcs_defines.vh ====
`ifndef PCS_DEFINES_VH
`define PCS_DEFINES_VH

// ---------------------------------------------------------------
// Register word indexes (byte address = index * 4)
// ---------------------------------------------------------------
`define PCS_IDX_CTRL    5'h00
`define PCS_IDX_PLL2    5'h01
`define PCS_IDX_PLL3    5'h02
`define PCS_IDX_DIVA    5'h03
`define PCS_IDX_DIVB    5'h04
`define PCS_IDX_DIVCD   5'h05
`define PCS_IDX_SRC     5'h06
`define PCS_IDX_SUSP    5'h07
`define PCS_IDX_STAT    5'h08
`define PCS_IDX_PLL1    5'h09
`define PCS_TBL_PAGE    2'h2

// ---------------------------------------------------------------
// Control word fields and reset value
// ---------------------------------------------------------------
`define PCS_CTL_SDEN    0
`define PCS_CTL_SUSPM   1
`define PCS_CTL_XBUF    2
`define PCS_CTL_BYP     3
`define PCS_CTL_DRV     4
`define PCS_CTL_CAP     6
`define PCS_CTL_OUTPUT_E_CLOCK    12
`define PCS_CTL_PEN     14
`define PCS_CTRL_RST    32'h0001d805

// ---------------------------------------------------------------
// PLL word, table row and divider word fields
// ---------------------------------------------------------------
`define PCS_Q_LO        0
`define PCS_P_LO        8
`define PCS_ROW_DSEL    19
`define PCS_DIV1_LO     8
`define PCS_PLL_RST     32'h00000000
`define PCS_DIV_RST     32'h00000000
`define PCS_SRC_RST     32'h00000000
`define PCS_SUSP_RST    32'h00000000

// ---------------------------------------------------------------
// Output E divider codes
// ---------------------------------------------------------------
`define PCS_OUTPUT_E_CLOCK_OFF    2'h0
`define PCS_OUTPUT_E_CLOCK_DIV4   2'h1
`define PCS_OUTPUT_E_CLOCK_DIV2   2'h2
`define PCS_OUTPUT_E_CLOCK_DIV3   2'h3

// ---------------------------------------------------------------
// Crystal load capacitance scale, in femtofarads
// ---------------------------------------------------------------
`define PCS_CAP_STEP_FF 375
`define PCS_CAP_MIN_FF  6000
`define PCS_CAP_MAX_FF  30000

`endif

// ==== core/pcs_freq_mem.v ====
`timescale 1ns/10ps

// ---------------------------------------------------------------
// Eight-row frequency table, one write and two registered reads
// ---------------------------------------------------------------
module pcs_freq_mem (
	input  wire        core_clk,  // Reference clock
	input  wire        reset,     // Async reset, high
	input  wire        wr_en,     // Row write strobe
	input  wire [2:0]  wr_addr,   // Row written
	input  wire [19:0] wr_data,   // Row contents
	input  wire [2:0]  rda_addr,  // Live select index
	output reg  [19:0] rda_data,  // Live row, registered
	input  wire [2:0]  rdb_addr,  // Bus read row
	output reg  [19:0] rdb_data   // Bus row, registered
);

	reg [19:0] mem_r [0:7];
	integer    i;

	// Rows cleared on reset so no unknown reaches the PLL
	always @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			for (i = 0; i < 8; i = i + 1)
				mem_r[i] <= 20'h00000;
			rda_data <= 20'h00000;
			rdb_data <= 20'h00000;
		end
		else
		begin
			if (wr_en)
				mem_r[wr_addr] <= wr_data;
			rda_data <= mem_r[rda_addr];
			rdb_data <= mem_r[rdb_addr];
		end
	end

endmodule // pcs_freq_mem

// ==== core/pcs_top.v ====
// Functional notes
// - Latch select_bit0/1 once at startup
// - Three select bits index eight-row PLL1 table
// - select_bit2 flips PLL1 and A/B divider setting
// - A and B share one divider register select
// - Divider changes apply only at period end
// - Each PLL gets 8-bit Q, 11-bit P
// - PLL1 feeds crosspoint and /2,/3,/4 output E
// - PLL2/PLL3 crosspoint only, serially programmed
// - PLL1 set by registers or select pins
// - Six-bit crystal load capacitance code
// - Load capacitors bypassable for driven input
// - Oscillator drive strength is configurable
// - Enable pin low tristates, optionally shuts down
// - select_bit2 is index bit or suspend input
// - Buffered reference clock output
// - Latched pins then act as serial port
// - Suspended PLL stops logic, output just tristates
// - Shutdown stops PLLs, counters, oscillator
//
// The AHB-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/10ps
`include "pcs_defines.vh"

module pcs_top (
	input  wire        core_clk,               // Reference clock
	input  wire        reset,                  // Async reset, high
	input  wire        hsel,                   // AHB slave select
	input  wire [31:0] haddr,                  // AHB address
	input  wire [1:0]  htrans,                 // AHB transfer type
	input  wire        hwrite,                 // AHB write
	input  wire [2:0]  hsize,                  // AHB size, word only
	input  wire [31:0] hwdata,                 // AHB write data
	input  wire        hready,                 // AHB bus ready
	output reg  [31:0] hrdata,                 // AHB read data
	output wire        hreadyout,              // AHB slave ready
	output wire        hresp,                  // AHB response
	input  wire        select_bit0,            // Select 0 / serial data
	input  wire        select_bit1,            // Select 1 / serial clock
	input  wire        select_bit2,            // Select 2 / suspend
	input  wire        output_enable_shutdown, // Low: tristate/off
	input  wire [2:0]  pll_tick,               // PLL3..1 edge ticks
	output reg         serial_data_in,         // Serial data to port
	output reg         serial_clock_in,        // Serial clock to port
	output wire        serial_port_active,     // Pins belong to port
	output wire [7:0]  pll1_q,                 // PLL1 pre-divider
	output wire [10:0] pll1_p,                 // PLL1 feedback
	output wire [7:0]  pll2_q,                 // PLL2 pre-divider
	output wire [10:0] pll2_p,                 // PLL2 feedback
	output wire [7:0]  pll3_q,                 // PLL3 pre-divider
	output wire [10:0] pll3_p,                 // PLL3 feedback
	output wire [2:0]  pll_enable,             // PLL3..1 run
	output wire        osc_enable,             // Oscillator run
	output wire [5:0]  osc_cap_code,           // Load cap code
	output wire [1:0]  osc_drive,              // Inverter drive
	output wire        cap_bypass,             // Bypass load caps
	output wire        reference_buffer_out,   // Buffered reference
	output wire        output_a_clock,         // Clock A
	output wire        output_b_clock,         // Clock B
	output wire        output_c_clock,         // Clock C
	output wire        output_d_clock,         // Clock D
	output wire        output_e_clock,         // Clock E
	output wire        output_a_oe,            // Clock A enable
	output wire        output_b_oe,            // Clock B enable
	output wire        output_c_oe,            // Clock C enable
	output wire        output_d_oe,            // Clock D enable
	output wire        output_e_oe             // Clock E enable
);

	// ---------------------------------------------------------------
	// Declarations
	// ---------------------------------------------------------------
	localparam [3:0] BS_IDLE = 4'b0001;
	localparam [3:0] BS_WR   = 4'b0010;
	localparam [3:0] BS_RD1  = 4'b0100;
	localparam [3:0] BS_RD2  = 4'b1000;

	reg  [3:0]  bus_st_r;
	reg  [3:0]  bus_st_nxt;
	reg  [4:0]  bus_idx_r;
	reg  [31:0] ctrl_r;
	reg  [31:0] pll2_r;
	reg  [31:0] pll3_r;
	reg  [31:0] diva_r;
	reg  [31:0] divb_r;
	reg  [31:0] divcd_r;
	reg  [31:0] src_r;
	reg  [31:0] susp_r;
	reg  [31:0] rd_mux;
	reg         latched_r;
	reg         s0_lat_r;
	reg         s1_lat_r;
	reg         s2_meta_r;
	reg         s2_sync_r;
	reg  [1:0]  e_cnt_r;
	reg  [1:0]  e_mod_r;
	reg         e_out_r;
	wire        take_w;
	wire        wr_en_w;
	wire        tbl_we_w;
	wire [2:0]  index_w;
	wire [19:0] row_live_w;
	wire [19:0] row_bus_w;
	wire        divsel_w;
	wire        oe_low_w;
	wire        full_sd_w;
	wire        susp_act_w;
	wire [3:0]  src_tick_w;
	wire [3:0]  src_run_w;
	wire [27:0] div_req_w;
	wire [3:0]  clk_w;
	wire [3:0]  div_on_w;
	wire [1:0]  e_code_w;
	wire [1:0]  e_req_w;
	wire [7:0]  susp_mask_w;

	// Pick one of the four crosspoint sources by its 2-bit code
	function pcs_src_pick;
		input [3:0] vec;
		input [1:0] sel;
		begin
			pcs_src_pick = vec[sel];
		end
	endfunction

	// ---------------------------------------------------------------
	// AHB-Lite slave
	// ---------------------------------------------------------------
	// Reads cost one wait state because hrdata comes from a flop
	assign hreadyout = (bus_st_r != BS_RD1);
	assign hresp     = 1'b0;
	assign take_w    = hsel & htrans[1] & hready & hreadyout;
	assign wr_en_w   = (bus_st_r == BS_WR);
	assign tbl_we_w  = wr_en_w & (bus_idx_r[4:3] == `PCS_TBL_PAGE);

	// Bus phase sequencing
	always @*
	begin
		bus_st_nxt = BS_IDLE;
		case (bus_st_r)
			BS_RD1:
				bus_st_nxt = BS_RD2;
			BS_IDLE, BS_WR, BS_RD2:
				if (take_w)
					bus_st_nxt = hwrite ? BS_WR : BS_RD1;
			default:
				bus_st_nxt = BS_IDLE;
		endcase
	end

	// Address phase capture and read data register
	always @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			bus_st_r  <= BS_IDLE;
			bus_idx_r <= 5'h00;
			hrdata    <= 32'h00000000;
		end
		else
		begin
			bus_st_r <= bus_st_nxt;
			if (take_w)
				bus_idx_r <= haddr[6:2];
			if (bus_st_r == BS_RD1)
				hrdata <= rd_mux;
		end
	end

	// Read decode; unmapped words read zero
	always @*
	begin
		rd_mux = 32'h00000000;
		if (bus_idx_r[4:3] == `PCS_TBL_PAGE)
			rd_mux = {12'h000, row_bus_w};
		else
			case (bus_idx_r)
				`PCS_IDX_CTRL:  rd_mux = ctrl_r;
				`PCS_IDX_PLL2:  rd_mux = pll2_r;
				`PCS_IDX_PLL3:  rd_mux = pll3_r;
				`PCS_IDX_DIVA:  rd_mux = diva_r;
				`PCS_IDX_DIVB:  rd_mux = divb_r;
				`PCS_IDX_DIVCD: rd_mux = divcd_r;
				`PCS_IDX_SRC:   rd_mux = src_r;
				`PCS_IDX_SUSP:  rd_mux = susp_r;
				`PCS_IDX_STAT:  rd_mux = {25'h0000000, full_sd_w,
					susp_act_w, divsel_w, latched_r, index_w};
				`PCS_IDX_PLL1:  rd_mux = {13'h0000, row_live_w[18:0]};
				default:        rd_mux = 32'h00000000;
			endcase
	end

	// Register writes in the data phase
	always @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			ctrl_r  <= `PCS_CTRL_RST;
			pll2_r  <= `PCS_PLL_RST;
			pll3_r  <= `PCS_PLL_RST;
			diva_r  <= `PCS_DIV_RST;
			divb_r  <= `PCS_DIV_RST;
			divcd_r <= `PCS_DIV_RST;
			src_r   <= `PCS_SRC_RST;
			susp_r  <= `PCS_SUSP_RST;
		end
		else if (wr_en_w)
		begin
			case (bus_idx_r)
				`PCS_IDX_CTRL:  ctrl_r  <= {15'h0000, hwdata[16:0]};
				`PCS_IDX_PLL2:  pll2_r  <= {13'h0000, hwdata[18:0]};
				`PCS_IDX_PLL3:  pll3_r  <= {13'h0000, hwdata[18:0]};
				`PCS_IDX_DIVA:  diva_r  <= {17'h00000, hwdata[14:0]};
				`PCS_IDX_DIVB:  divb_r  <= {17'h00000, hwdata[14:0]};
				`PCS_IDX_DIVCD: divcd_r <= {17'h00000, hwdata[14:0]};
				`PCS_IDX_SRC:   src_r   <= {24'h000000, hwdata[7:0]};
				`PCS_IDX_SUSP:  susp_r  <= {24'h000000, hwdata[7:0]};
				default:        ctrl_r  <= ctrl_r;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Select pins and serial port hand-off
	// ---------------------------------------------------------------
	// One capture right after reset release; the pins then belong
	// to the serial port and are never sampled as selects again
	always @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			latched_r <= 1'b0;
			s0_lat_r  <= 1'b0;
			s1_lat_r  <= 1'b0;
		end
		else if (!latched_r)
		begin
			s0_lat_r  <= select_bit0;
			s1_lat_r  <= select_bit1;
			latched_r <= 1'b1;
		end
	end

	// Forward the pins to the serial port once latched, idle high
	always @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			serial_data_in  <= 1'b1;
			serial_clock_in <= 1'b1;
		end
		else if (latched_r)
		begin
			serial_data_in  <= select_bit0;
			serial_clock_in <= select_bit1;
		end
	end
	assign serial_port_active = latched_r;

	// Two-flop synchroniser; only the second flop is used
	always @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			s2_meta_r <= 1'b0;
			s2_sync_r <= 1'b0;
		end
		else
		begin
			s2_meta_r <= select_bit2;
			s2_sync_r <= s2_meta_r;
		end
	end

	// In suspend mode the pin no longer steers the index
	assign susp_act_w = ctrl_r[`PCS_CTL_SUSPM] & ~s2_sync_r;
	assign index_w    = {s2_sync_r & ~ctrl_r[`PCS_CTL_SUSPM],
		s1_lat_r, s0_lat_r};

	// ---------------------------------------------------------------
	// Frequency table and PLL settings
	// ---------------------------------------------------------------
	pcs_freq_mem u_freq_mem (
		.core_clk (core_clk),
		.reset    (reset),
		.wr_en    (tbl_we_w),
		.wr_addr  (bus_idx_r[2:0]),
		.wr_data  (hwdata[19:0]),
		.rda_addr (index_w),
		.rda_data (row_live_w),
		.rdb_addr (haddr[4:2]),
		.rdb_data (row_bus_w)
	);

	// PLL1 follows the live row, so pins or writes both retune it
	assign pll1_q   = row_live_w[`PCS_Q_LO+7:`PCS_Q_LO];
	assign pll1_p   = row_live_w[`PCS_P_LO+10:`PCS_P_LO];
	assign divsel_w = row_live_w[`PCS_ROW_DSEL];
	assign pll2_q   = pll2_r[`PCS_Q_LO+7:`PCS_Q_LO];
	assign pll2_p   = pll2_r[`PCS_P_LO+10:`PCS_P_LO];
	assign pll3_q   = pll3_r[`PCS_Q_LO+7:`PCS_Q_LO];
	assign pll3_p   = pll3_r[`PCS_P_LO+10:`PCS_P_LO];

	// ---------------------------------------------------------------
	// Power management and oscillator
	// ---------------------------------------------------------------
	assign oe_low_w    = ~output_enable_shutdown;
	assign full_sd_w   = oe_low_w & ctrl_r[`PCS_CTL_SDEN];
	assign susp_mask_w = susp_r[7:0] & {8{susp_act_w}};
	// PLLs come back on as soon as shutdown ends and relock there
	assign pll_enable  = ctrl_r[`PCS_CTL_PEN+2:`PCS_CTL_PEN]
		& ~susp_mask_w[2:0] & {3{~full_sd_w}};
	assign osc_enable  = ~full_sd_w;
	assign osc_cap_code = ctrl_r[`PCS_CTL_CAP+5:`PCS_CTL_CAP];
	assign osc_drive   = ctrl_r[`PCS_CTL_DRV+1:`PCS_CTL_DRV];
	assign cap_bypass  = ctrl_r[`PCS_CTL_BYP];
	// Gated copy of the reference; glitch risk only on enable change
	assign reference_buffer_out = core_clk & ctrl_r[`PCS_CTL_XBUF]
		& ~full_sd_w;

	// ---------------------------------------------------------------
	// Crosspoint and output dividers A to D
	// ---------------------------------------------------------------
	assign src_run_w  = {pll_enable, 1'b1};
	assign src_tick_w = {pll_tick & pll_enable, 1'b1};
	assign div_req_w  = {divcd_r[`PCS_DIV1_LO+6:`PCS_DIV1_LO],
		divcd_r[6:0],
		divsel_w ? divb_r[`PCS_DIV1_LO+6:`PCS_DIV1_LO] : divb_r[6:0],
		divsel_w ? diva_r[`PCS_DIV1_LO+6:`PCS_DIV1_LO] : diva_r[6:0]};

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1)
		begin : g_div
			reg  [6:0] cnt_r;
			reg  [6:0] cur_r;
			reg        out_r;
			wire [1:0] sel = src_r[2*gi+1:2*gi];
			wire       tick = pcs_src_pick(src_tick_w, sel);
			wire       halt = full_sd_w | ~pcs_src_pick(src_run_w, sel);
			wire [6:0] req = div_req_w[7*gi+6:7*gi];
			wire [7:0] half = ({1'b0, cur_r} + 8'h01) >> 1;
			wire       wrap = (cnt_r >= cur_r - 7'h01);
			wire [6:0] cnt_nxt = wrap ? 7'h00 : cnt_r + 7'h01;

			// New value taken only at the end of a full period
			always @(posedge core_clk or posedge reset)
			begin
				if (reset)
				begin
					cnt_r <= 7'h00;
					cur_r <= 7'h00;
					out_r <= 1'b0;
				end
				else if (halt || cur_r == 7'h00)
				begin
					cnt_r <= 7'h00;
					cur_r <= req;
					out_r <= 1'b0;
				end
				else if (tick)
				begin
					cnt_r <= cnt_nxt;
					if (wrap)
						cur_r <= req;
					out_r <= ({1'b0, cnt_nxt} < half);
				end
			end
			assign clk_w[gi]    = out_r;
			assign div_on_w[gi] = (cur_r != 7'h00);
		end
	endgenerate

	// ---------------------------------------------------------------
	// Output E post-divider on PLL1
	// ---------------------------------------------------------------
	assign e_code_w = ctrl_r[`PCS_CTL_OUTPUT_E_CLOCK+1:`PCS_CTL_OUTPUT_E_CLOCK];
	// Code to modulus; zero leaves clock E stopped
	assign e_req_w  = (e_code_w == `PCS_OUTPUT_E_CLOCK_DIV4) ? 2'h3 :
		(e_code_w == `PCS_OUTPUT_E_CLOCK_DIV2) ? 2'h1 :
		(e_code_w == `PCS_OUTPUT_E_CLOCK_DIV3) ? 2'h2 : 2'h0;

	// Modulus reloads at period end so code changes stay clean
	always @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			e_cnt_r <= 2'h0;
			e_mod_r <= 2'h0;
			e_out_r <= 1'b0;
		end
		else if (full_sd_w || !pll_enable[0] || e_mod_r == 2'h0)
		begin
			e_cnt_r <= 2'h0;
			e_out_r <= 1'b0;
			e_mod_r <= e_req_w;
		end
		else if (pll_tick[0])
		begin
			e_cnt_r <= (e_cnt_r == e_mod_r) ? 2'h0 : e_cnt_r + 2'h1;
			// Three bits so that the /4 half period does not wrap
			e_out_r <= (e_cnt_r == e_mod_r) || ({1'b0, e_cnt_r} + 3'h1 <
				({1'b0, e_mod_r} + 3'h1) >> 1);
			if (e_cnt_r == e_mod_r)
				e_mod_r <= e_req_w;
		end
	end

	// ---------------------------------------------------------------
	// Pin outputs
	// ---------------------------------------------------------------
	assign output_a_clock = clk_w[0];
	assign output_b_clock = clk_w[1];
	assign output_c_clock = clk_w[2];
	assign output_d_clock = clk_w[3];
	assign output_e_clock = e_out_r;
	// Low enable pin tristates every output in either mode
	assign output_a_oe = ~oe_low_w & div_on_w[0] & ~susp_mask_w[3];
	assign output_b_oe = ~oe_low_w & div_on_w[1] & ~susp_mask_w[4];
	assign output_c_oe = ~oe_low_w & div_on_w[2] & ~susp_mask_w[5];
	assign output_d_oe = ~oe_low_w & div_on_w[3] & ~susp_mask_w[6];
	assign output_e_oe = ~oe_low_w & (e_mod_r != 2'h0)
		& ~susp_mask_w[7];

endmodule // pcs_top

// ==== verif/pcs_board_model.sv ====
`timescale 1ns/10ps

// ---------------------------------------------------------------
// Board pins and PLL edge source
// ---------------------------------------------------------------
module pcs_board_model (
	input	wire		core_clk,		// Reference clock
	input	wire		reset,			// Reset, high
	input	wire	[3:0]	pin_cfg,		// Oe, s2, s1, s0 levels
	output	wire		select_bit0,		// Select pin 0
	output	wire		select_bit1,		// Select pin 1
	output	wire		select_bit2,		// Select pin 2
	output	wire		output_enable_shutdown,	// Enable pin
	output	reg	[2:0]	pll_tick		// PLL3..1 edges
);
	reg	[3:0]	tick_cnt_r;

	// Static straps, held through reset so the startup latch sees them
	assign {output_enable_shutdown, select_bit2, select_bit1,
		select_bit0} = pin_cfg;
	// Driven reference only, so crystal feedback stays open

	// PLL1, 2, 3 edges every 2, 3, 4 cycles; 12 is their common period
	always @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			tick_cnt_r <= 4'h0;
			pll_tick <= 3'h0;
		end
		else
		begin
			tick_cnt_r <= (tick_cnt_r == 4'hb) ? 4'h0 : tick_cnt_r + 4'h1;
			pll_tick <= {tick_cnt_r[1:0] == 2'h0,
				tick_cnt_r % 4'h3 == 4'h0, !tick_cnt_r[0]};
		end
	end
endmodule // pcs_board_model

// ==== verif/pcs_top_properties.sv ====
`timescale 1ns/10ps

// ---------------------------------------------------------------
// Port checks of the clock select control
// ---------------------------------------------------------------
module pcs_top_checker (
	input	wire		core_clk,		// Clock
	input	wire		reset,			// Reset
	input	wire		hsel,			// Select
	input	wire	[1:0]	htrans,			// Type
	input	wire		hwrite,			// Write
	input	wire		hready,			// Ready in
	input	wire		hreadyout,		// Ready out
	input	wire		hresp,			// Response
	input	wire		select_bit0,		// Pin 0
	input	wire		select_bit2,		// Pin 2
	input	wire		output_enable_shutdown,	// Enable pin
	input	wire	[2:0]	pll_tick,		// Ticks
	input	wire		serial_data_in,		// Serial data
	input	wire		serial_port_active,	// Port owns pins
	input	wire	[7:0]	pll1_q,			// PLL1 Q
	input	wire	[10:0]	pll1_p,			// PLL1 P
	input	wire	[2:0]	pll_enable,		// PLL run
	input	wire		osc_enable,		// Osc run
	input	wire	[5:0]	osc_cap_code,		// Cap code
	input	wire	[1:0]	osc_drive,		// Drive
	input	wire		cap_bypass,		// Cap bypass
	input	wire		output_e_clock,		// Clock E
	input	wire		output_a_oe,		// Enable A
	input	wire		output_b_oe,		// Enable B
	input	wire		output_c_oe,		// Enable C
	input	wire		output_d_oe,		// Enable D
	input	wire		output_e_oe		// Enable E
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	// Bus phases
	sequence rd_taken;
		hsel && htrans[1] && hready && hreadyout && !hwrite;
	endsequence
	sequence wr_taken;
		hsel && htrans[1] && hready && hreadyout && hwrite;
	endsequence
	sequence one_wait;
		!hreadyout ##1 hreadyout;
	endsequence

	a_read_wait: assert property (rd_taken |=> one_wait)
		else $error("read data phase not one wait");
	a_write_nowait: assert property (wr_taken |=> hreadyout)
		else $error("write data phase stalled");
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("response not okay");
	a_port_hold: assert property (serial_port_active |=> serial_port_active)
		else $error("serial port dropped");
	a_serial_follow: assert property ($past(serial_port_active) |->
		serial_data_in == $past(select_bit0))
		else $error("serial data not following pin");
	a_oe_off: assert property (!output_enable_shutdown |-> !(output_a_oe ||
		output_b_oe || output_c_oe || output_d_oe || output_e_oe))
		else $error("output driving with enable pin low");
	a_sd_stop: assert property (!osc_enable |->
		pll_enable == 3'h0 && !output_enable_shutdown)
		else $error("shutdown state inconsistent");
	// Two sync flops: the live row must not move for two edges
	a_sync_sel: assert property ($changed(select_bit2) |=>
		($stable(pll1_q) && $stable(pll1_p)) [*2])
		else $error("select reached PLL1 unsynchronised");
	a_e_on_tick: assert property ($changed(output_e_clock) && output_e_oe &&
		$past(output_e_oe) |-> $past(pll_tick[0]))
		else $error("clock E moved without PLL1 edge");
	a_reset_cfg: assert property ($past(reset) |-> osc_cap_code == 6'h20 &&
		osc_drive == 2'h0 && !cap_bypass && pll_enable == 3'h7)
		else $error("oscillator reset setting wrong");
endmodule // pcs_top_checker

bind pcs_top pcs_top_checker i_pcs_top_checker (.*);

// ==== verif/pcs_top_bench.sv ====
`timescale 1ns/10ps

// ---------------------------------------------------------------
// Bench of the clock select control
// ---------------------------------------------------------------
module pcs_top_bench;
	reg		core_clk, reset, hsel, hwrite;
	reg	[31:0]	haddr, hwdata;
	reg	[1:0]	htrans;
	reg	[2:0]	hsize;
	reg	[3:0]	pin_cfg;
	wire	[31:0]	hrdata;
	wire		hreadyout, hresp, hready, serial_data_in, serial_clock_in;
	wire		serial_port_active, osc_enable, cap_bypass;
	wire		reference_buffer_out, output_enable_shutdown;
	wire	[7:0]	pll1_q, pll2_q, pll3_q;
	wire	[10:0]	pll1_p, pll2_p, pll3_p;
	wire	[2:0]	pll_enable, pll_tick;
	wire	[5:0]	osc_cap_code;
	wire	[1:0]	osc_drive;
	wire		select_bit0, select_bit1, select_bit2;
	wire		output_a_clock, output_b_clock, output_c_clock;
	wire		output_d_clock, output_e_clock, output_a_oe;
	wire		output_b_oe, output_c_oe, output_d_oe, output_e_oe;
	wire	[4:0]	clk_o, oe_o;
	int		err_count = 0;
	int		n_tests = 0;
	int		k, p;
	logic	[31:0]	d;

	// One slave, so its ready is the bus ready
	assign hready = hreadyout;
	assign clk_o = {output_e_clock, output_d_clock, output_c_clock,
		output_b_clock, output_a_clock};
	assign oe_o = {output_e_oe, output_d_oe, output_c_oe,
		output_b_oe, output_a_oe};

	pcs_top i_pcs_top (.*);
	pcs_board_model i_pcs_board_model (.*);

	// 40 MHz reference
	initial
	begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	// ---------------------------------------------------------------
	// Tasks
	// ---------------------------------------------------------------
	task end_of_test;
		begin
			if (err_count == 0 && n_tests > 0)
				$display("[ PASS ]");
			else
				$display("[ FAIL ]");
			$finish;
		end
	endtask

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		begin
			n_tests++;
			if (g !== e)
			begin
				$display("Error %s expected %h seen %h", nm, e, g);
				err_count++;
			end
		end
	endtask

	// Single word transfer; a stuck wait ends only by the watchdog
	task bus(input logic w, input logic [31:0] a, input logic [31:0] wd,
		output logic [31:0] rv);
		begin
			hsel <= 1'b1;
			haddr <= a;
			htrans <= 2'h2;
			hwrite <= w;
			@(posedge core_clk);
			while (hreadyout !== 1'b1) @(posedge core_clk);
			hsel <= 1'b0;
			htrans <= 2'h0;
			hwdata <= wd;
			@(posedge core_clk);
			while (hreadyout !== 1'b1) @(posedge core_clk);
			rv = hrdata;
		end
	endtask

	// Extra edge lets the register update reach the outputs
	task wr(input logic [31:0] a, input logic [31:0] wd);
		logic [31:0] x;
		begin
			bus(1'b1, a, wd, x);
			@(posedge core_clk);
		end
	endtask

	task step(inout int c);
		begin
			@(posedge core_clk);
			c++;
		end
	endtask

	// Rising edge to rising edge, after syncing to one
	task meas(input int i, output int q);
		int n;
		begin
			n = 0;
			while (clk_o[i] === 1'b1 && n < 300) step(n);
			while (clk_o[i] !== 1'b1 && n < 300) step(n);
			q = 0;
			while (clk_o[i] === 1'b1 && q < 300) step(q);
			while (clk_o[i] !== 1'b1 && q < 300) step(q);
		end
	endtask

	// Second period, so a pending divider change has landed
	task per(input int i, input int e);
		begin
			meas(i, p);
			meas(i, p);
			chk("period", e, p);
		end
	endtask

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial
	begin
		reset = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		pin_cfg = 4'h9;
		repeat (5) @(posedge core_clk);
		reset <= 1'b0;
		@(posedge core_clk);
		bus(1'b0, 32'h00, 32'h0, d);
		chk("ctrl", 32'h0001d805, d);
		bus(1'b0, 32'h20, 32'h0, d);
		chk("stat", 32'h00000009, d);
		bus(1'b0, 32'h3c, 32'h0, d);
		chk("unmapped", 32'h0, d);
		wr(32'h04, 32'hffffffff);
		wr(32'h08, 32'h0005a53c);
		bus(1'b0, 32'h04, 32'h0, d);
		chk("pll2 word", 32'h0007ffff, d);
		chk("pll2", 19'h7ffff, {pll2_p, pll2_q});
		chk("pll3", 19'h5a53c, {pll3_p, pll3_q});
		for (k = 0; k < 8; k++)
			wr(32'h40 + 4 * k, {12'h0, k[2:2], 11'(11'h100 + k),
				8'(8'h10 + k)});
		wr(32'h0c, 32'h00000302);
		wr(32'h10, 32'h00000402);
		bus(1'b0, 32'h24, 32'h0, d);
		chk("pll1 row1", 32'h00010111, d);
		bus(1'b0, 32'h54, 32'h0, d);
		chk("row5", 32'h00090515, d);
		per(0, 2);
		per(1, 2);
		pin_cfg <= 4'hd;
		repeat (5) @(posedge core_clk);
		chk("pll1 row5", 19'h10515, {pll1_p, pll1_q});
		per(0, 3);
		per(1, 4);
		for (k = 1; k < 4; k++)
		begin
			wr(32'h00, 32'h0001c804 | (k << 12));
			per(4, (k == 1) ? 8 : (k == 2) ? 4 : 6);
		end
		wr(32'h00, 32'h0001c804);
		// Clock E stops only at the end of its running period
		repeat (8) @(posedge core_clk);
		chk("e off", 1'b0, output_e_oe);
		wr(32'h00, 32'h0001dffc);
		chk("osc", 9'h1ff, {osc_cap_code, osc_drive, cap_bypass});
		#1 chk("xbuf", 1'b1, reference_buffer_out);
		@(posedge core_clk);
		pin_cfg <= 4'h5;
		@(posedge core_clk);
		chk("oe low", 5'h0, oe_o);
		chk("no sd", 4'hf, {osc_enable, pll_enable});
		wr(32'h00, 32'h0001dffd);
		chk("sd", 4'h0, {osc_enable, pll_enable});
		#1 chk("xbuf sd", 1'b0, reference_buffer_out);
		@(posedge core_clk);
		pin_cfg <= 4'hd;
		@(posedge core_clk);
		chk("relock", 4'hf, {osc_enable, pll_enable});
		// PLL1 suspended together with clock E, its only user
		wr(32'h1c, 32'h00000081);
		wr(32'h00, 32'h0001dffe);
		pin_cfg <= 4'h9;
		repeat (4) @(posedge core_clk);
		chk("susp pll", 3'h6, pll_enable);
		chk("susp oe", 5'h03, oe_o);
		bus(1'b0, 32'h20, 32'h0, d);
		chk("susp stat", 6'h29, d[5:0]);
		pin_cfg <= 4'he;
		repeat (2) @(posedge core_clk);
		chk("serial", 2'h2, {serial_clock_in, serial_data_in});
		bus(1'b0, 32'h20, 32'h0, d);
		chk("no relatch", 4'h9, d[3:0]);
		// C on PLL1 by 5, D on PLL2 by 6
		wr(32'h14, 32'h00000605);
		wr(32'h18, 32'h00000090);
		per(2, 10);
		per(3, 18);
		end_of_test;
	end

	// Watchdog well beyond the few hundred cycles the run needs
	initial
	begin
		#200000;
		err_count++;
		end_of_test;
	end
endmodule // pcs_top_bench
